// ===== shared/tsac_pkg.sv
// Constants and types shared by the touch ADC status and reference control block
package tsac_pkg;

    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
    localparam int unsigned WORD_BITS   = 16;
    localparam int unsigned CHAN_COUNT  = 9;

    // Serial command word layout
    localparam int unsigned CMD_READ_POS = 15;
    localparam int unsigned CMD_PAGE_LSB = 11;
    localparam int unsigned CMD_ADDR_LSB = 5;
    localparam logic [3:0]  BIT_LAST     = 4'hf;

    // Pages and register addresses
    localparam logic [3:0]  PAGE_RESULTS   = 4'h0;
    localparam logic [3:0]  PAGE_CONTROL   = 4'h1;
    localparam logic [5:0]  ADDR_STATUS    = 6'h01;
    localparam logic [5:0]  ADDR_RESERVED  = 6'h02;
    localparam logic [5:0]  ADDR_REF_CTL   = 6'h03;
    localparam logic [5:0]  CHAN_ADDR_END  = 6'(CHAN_COUNT);
    localparam logic [3:0]  CHAN_STORE_END = 4'(CHAN_COUNT);
    localparam logic [15:0] RESERVED_WORD  = 16'hffff;

    // Status word fields, channel order X Y Z1 Z2 BAT1 BAT2 AUX TEMP1 TEMP2
    localparam int unsigned POS_ANY_PENDING = 11;
    localparam int unsigned POS_HORIZ       = 10;
    localparam int unsigned POS_VERT        = 9;
    localparam int unsigned POS_PRESS_ONE   = 8;
    localparam int unsigned POS_PRESS_TWO   = 7;
    localparam int unsigned POS_BATT_ONE    = 6;
    localparam int unsigned POS_BATT_TWO    = 5;
    localparam int unsigned POS_AUX         = 4;
    localparam int unsigned POS_TEMP_ONE    = 2;
    localparam int unsigned POS_TEMP_TWO    = 1;
    localparam int unsigned FLAG_POS [CHAN_COUNT] = '{POS_HORIZ, POS_VERT, POS_PRESS_ONE,
        POS_PRESS_TWO, POS_BATT_ONE, POS_BATT_TWO, POS_AUX, POS_TEMP_ONE, POS_TEMP_TWO};

    // Reference control fields
    localparam int unsigned REF_CTL_W     = 5;
    localparam int unsigned REF_SRC_POS   = 4;
    localparam int unsigned REF_DLY_LSB   = 2;
    localparam int unsigned REF_SLEEP_POS = 1;
    localparam int unsigned REF_LVL_POS   = 0;
    localparam logic [4:0]  REF_CTL_RST   = 5'h02;

    // Reference settling times
    localparam int unsigned DLY_100_US       = 100;
    localparam int unsigned DLY_500_US       = 500;
    localparam int unsigned DLY_1000_US      = 1000;
    localparam int unsigned DLY_CNT_W        = 14;
    localparam int unsigned DLY_100_CYC      = DLY_100_US * CYC_PER_US;
    localparam int unsigned DLY_500_CYC_DEF  = DLY_500_US * CYC_PER_US;
    localparam int unsigned DLY_1000_CYC_DEF = DLY_1000_US * CYC_PER_US;

    typedef enum logic [1:0] {
        REF_IDLE   = 2'b00,
        REF_SETTLE = 2'b01,
        REF_READY  = 2'b10
    } tsac_ref_state_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  chan;
        logic [15:0] data;
    } tsac_store_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } tsac_spi_pins_t;

    localparam tsac_spi_pins_t PINS_IDLE = 3'h2;

    typedef struct packed {
        logic use_internal;
        logic power_on;
        logic level_high;
        logic ready;
    } tsac_ref_out_t;

    typedef struct packed {
        tsac_spi_pins_t          pin_s1;
        tsac_spi_pins_t          pin_s2;
        logic                    sclk_prev;
        logic [3:0]              bit_cnt;
        logic                    in_cmd;
        logic                    is_read;
        logic [3:0]              page;
        logic [5:0]              addr;
        logic [15:0]             shift_in;
        logic [15:0]             shift_out;
        logic                    miso;
        logic                    miso_oe;
        logic [CHAN_COUNT-1:0]   flags;
        logic                    any_pending;
        logic [REF_CTL_W-1:0]    ref_ctl;
        tsac_ref_state_t         ref_state;
        logic [DLY_CNT_W-1:0]    dly_cnt;
        tsac_ref_out_t           ref_out;
    } tsac_state_t;

    typedef struct packed {
        logic [CHAN_COUNT-1:0][15:0] words;
        logic [15:0]                 rd_data;
    } tsac_mem_state_t;

endpackage : tsac_pkg

// ===== design/tsac_result_mem.sv
// Result word memory with registered read data
module tsac_result_mem
    import tsac_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  rd_addr,
    output      logic [15:0] rd_data
);

    tsac_mem_state_t m;
    tsac_mem_state_t next_m;

    always_comb
    begin
        next_m = m;
        if (wr_en && wr_addr < CHAN_STORE_END)
        begin
            next_m.words[wr_addr] = wr_data;
        end
        // Out-of-range reads give zero rather than aliasing
        if (rd_addr < CHAN_STORE_END)
        begin
            next_m.rd_data = m.words[rd_addr];
        end
        else
        begin
            next_m.rd_data = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            m <= '0;
        end
        else if (ce)
        begin
            m <= next_m;
        end
    end

    assign rd_data = m.rd_data;

endmodule : tsac_result_mem

// ===== design/tsac_status_ref.sv
// Touch ADC result flags, reference control and serial register port
// Notes on behaviour
// R1: Stored X result sets flag until read
// R2: Stored Y result sets flag until read
// R3: Stored Z1 result sets flag until read
// R4: Stored Z2 result sets flag until read
// R5: Stored battery-one result sets flag until read
// R6: Stored battery-two result sets flag until read
// R7: Stored auxiliary result sets flag until read
// R8: Stored temperature-one result sets flag until read
// R9: Stored temperature-two result sets flag until read
// R10: Source bit: 0 external, 1 internal, reset 0
// R11: Settle delay field: 0, 100, 500, 1000 us
// R12: Delay only for internal, sleeping reference
// R13: Sleep bit 0 always on; reset 1
// R14: External source keeps internal reference off
// R15: Level bit: 0 low, 1 high; reset 0
// R16: Set-complete flag held until all read
// R17: Flag clears when result read finishes
module tsac_status_ref
    import tsac_pkg::*;
#(
    parameter logic [DLY_CNT_W-1:0] DLY_500_CYC  = DLY_CNT_W'(DLY_500_CYC_DEF),
    parameter logic [DLY_CNT_W-1:0] DLY_1000_CYC = DLY_CNT_W'(DLY_1000_CYC_DEF)
)
(
    input  wire logic           ref_clk,
    input  wire logic           srst,
    input  wire logic           ce,
    input  wire tsac_spi_pins_t spi_pins,
    output      logic           miso,
    output      logic           miso_oe,
    input  wire tsac_store_t    store,
    input  wire logic           set_done,
    input  wire logic           conv_req,
    output      tsac_ref_out_t  ref_out
);

    tsac_state_t          s;
    tsac_state_t          next_s;
    logic [15:0]          mem_rd_data;
    logic [15:0]          word_in;
    logic [15:0]          status_word;
    logic [15:0]          rd_word;
    logic [CHAN_COUNT-1:0] clr;
    logic [CHAN_COUNT-1:0] set;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 write_ref;
    logic                 gated;
    logic [DLY_CNT_W-1:0] dly_cyc;

    assign sclk_rise = s.pin_s2.sclk & ~s.sclk_prev;
    assign sclk_fall = ~s.pin_s2.sclk & s.sclk_prev;
    assign word_in   = {s.shift_in[14:0], s.pin_s2.mosi};
    assign gated     = s.ref_ctl[REF_SRC_POS] & s.ref_ctl[REF_SLEEP_POS];

    tsac_result_mem u_mem
    (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ce      (ce),
        .wr_en   (store.valid),
        .wr_addr (store.chan),
        .wr_data (store.data),
        .rd_addr (s.addr[3:0]),
        .rd_data (mem_rd_data)
    );

    always_comb
    begin
        status_word = '0;
        for (int i = 0; i < CHAN_COUNT; i++)
        begin
            status_word[FLAG_POS[i]] = s.flags[i];
        end
        status_word[POS_ANY_PENDING] = s.any_pending;
    end

    always_comb
    begin
        rd_word = '0;
        case (s.page)
            PAGE_RESULTS:
            begin
                if (s.addr < CHAN_ADDR_END)
                begin
                    rd_word = mem_rd_data;
                end
            end
            PAGE_CONTROL:
            begin
                case (s.addr)
                    ADDR_STATUS:   rd_word = status_word;
                    ADDR_RESERVED: rd_word = RESERVED_WORD;
                    ADDR_REF_CTL:  rd_word = {11'h000, s.ref_ctl};
                    default:       rd_word = '0;
                endcase
            end
            default: rd_word = '0;
        endcase
    end

    always_comb
    begin
        case (s.ref_ctl[REF_DLY_LSB +: 2])
            2'b00:   dly_cyc = '0;
            2'b01:   dly_cyc = DLY_CNT_W'(DLY_100_CYC);
            2'b10:   dly_cyc = DLY_500_CYC;
            2'b11:   dly_cyc = DLY_1000_CYC;
            default: dly_cyc = '0;
        endcase
    end

    always_comb
    begin
        next_s         = s;
        clr            = '0;
        set            = '0;
        write_ref      = 1'b0;
        next_s.pin_s1    = spi_pins;
        next_s.pin_s2    = s.pin_s1;
        next_s.sclk_prev = s.pin_s2.sclk;

        // Serial frame: command word, then auto-incrementing data words
        if (s.pin_s2.cs_n)
        begin
            next_s.bit_cnt = '0;
            next_s.in_cmd  = 1'b1;
            next_s.is_read = 1'b0;
        end
        else if (sclk_rise)
        begin
            next_s.shift_in = word_in;
            if (s.bit_cnt == BIT_LAST)
            begin
                next_s.bit_cnt = '0;
                if (s.in_cmd)
                begin
                    next_s.in_cmd  = 1'b0;
                    next_s.is_read = word_in[CMD_READ_POS];
                    next_s.page    = word_in[CMD_PAGE_LSB +: 4];
                    next_s.addr    = word_in[CMD_ADDR_LSB +: 6];
                end
                else
                begin
                    if (!s.is_read && s.page == PAGE_CONTROL && s.addr == ADDR_REF_CTL)
                    begin
                        write_ref = 1'b1;
                    end
                    // Last bit sampled by the host: the result is fully read
                    if (s.is_read && s.page == PAGE_RESULTS && s.addr < CHAN_ADDR_END)
                    begin
                        clr[s.addr[3:0]] = 1'b1; // R17
                    end
                    next_s.addr = s.addr + 6'h01;
                end
            end
            else
            begin
                next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
        end
        else if (sclk_fall && s.is_read && !s.in_cmd)
        begin
            // Word loads on the fall before its first rising edge
            if (s.bit_cnt == '0)
            begin
                next_s.miso      = rd_word[15];
                next_s.shift_out = {rd_word[14:0], 1'b0};
            end
            else
            begin
                next_s.miso      = s.shift_out[15];
                next_s.shift_out = {s.shift_out[14:0], 1'b0};
            end
        end
        next_s.miso_oe = ~s.pin_s2.cs_n & s.is_read & ~s.in_cmd;

        // Only the five documented bits are writable
        if (write_ref)
        begin
            next_s.ref_ctl = word_in[REF_CTL_W-1:0]; // R10 R11 R13 R15
        end

        // Result flags: a store in the same cycle as the read wins
        if (store.valid && store.chan < CHAN_STORE_END)
        begin
            set[store.chan] = 1'b1; // R1 R2 R3 R4 R5 R6 R7 R8 R9
        end
        next_s.flags = (s.flags & ~clr) | set; // R1 R2 R3 R4 R5 R6 R7 R8 R9

        if (set_done)
        begin
            next_s.any_pending = 1'b1; // R16
        end
        else if (clr != '0 && next_s.flags == '0)
        begin
            next_s.any_pending = 1'b0; // R16
        end

        // Reference settling sequence for each conversion request
        case (s.ref_state)
            REF_IDLE:
            begin
                if (conv_req)
                begin
                    if (gated && dly_cyc != '0)
                    begin
                        next_s.ref_state = REF_SETTLE; // R12
                        next_s.dly_cnt   = dly_cyc - 1'b1; // R11
                    end
                    else
                    begin
                        next_s.ref_state = REF_READY; // R12
                    end
                end
            end
            REF_SETTLE:
            begin
                if (!conv_req)
                begin
                    next_s.ref_state = REF_IDLE;
                end
                else if (s.dly_cnt == '0)
                begin
                    next_s.ref_state = REF_READY; // R11
                end
                else
                begin
                    next_s.dly_cnt = s.dly_cnt - 1'b1;
                end
            end
            REF_READY:
            begin
                if (!conv_req)
                begin
                    next_s.ref_state = REF_IDLE;
                end
            end
            default: next_s.ref_state = REF_IDLE;
        endcase

        next_s.ref_out.use_internal = s.ref_ctl[REF_SRC_POS]; // R10
        next_s.ref_out.level_high   = s.ref_ctl[REF_LVL_POS]; // R15
        // Sleeping reference wakes only while a conversion is requested
        next_s.ref_out.power_on = s.ref_ctl[REF_SRC_POS]
                                & (~s.ref_ctl[REF_SLEEP_POS] | conv_req); // R13 R14
        next_s.ref_out.ready    = (next_s.ref_state == REF_READY);
    end

    // Reset acts even while ce is low
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s         <= '0;
            s.pin_s1  <= PINS_IDLE;
            s.pin_s2  <= PINS_IDLE;
            s.in_cmd  <= 1'b1;
            s.ref_ctl <= REF_CTL_RST; // R10 R13 R15
            s.ref_state <= REF_IDLE;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    assign miso    = s.miso;
    assign miso_oe = s.miso_oe;
    assign ref_out = s.ref_out;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_store_sets_flag: assert property ( // R1 R2 R3 R4 R5 R6 R7 R8 R9
        ce && store.valid && store.chan < CHAN_STORE_END |=> s.flags[$past(store.chan)])
        else $error("stored result did not raise its flag");

    a_flag_held_unread: assert property ( // R17
        ce && clr == '0 |=> (s.flags & $past(s.flags)) == $past(s.flags))
        else $error("result flag fell without a completed read");

    a_read_clears_flag: assert property ( // R17
        ce && clr != '0 && !store.valid |=> (s.flags & $past(clr)) == '0)
        else $error("completed read left its flag set");

    a_done_sets_pending: assert property ( // R16
        ce && set_done |=> s.any_pending)
        else $error("set completion did not raise data available");

    a_pending_until_read: assert property ( // R16
        $fell(s.any_pending) |-> s.flags == '0 && $past(clr) != '0)
        else $error("data available dropped with results unread");

    a_ref_write_takes: assert property ( // R10
        ce && write_ref |=> s.ref_ctl == $past(word_in[REF_CTL_W-1:0]) ##1
            (!ce || ref_out.use_internal == s.ref_ctl[REF_SRC_POS]))
        else $error("reference control write not applied");

    a_settle_start_100: assert property ( // R11
        ce && s.ref_state == REF_IDLE && conv_req && gated
            && s.ref_ctl[REF_DLY_LSB +: 2] == 2'b01
        |=> s.ref_state == REF_SETTLE && s.dly_cnt == DLY_CNT_W'(DLY_100_CYC - 1))
        else $error("settle delay did not start at the selected length");

    a_settle_end_ready: assert property ( // R11
        ce && s.ref_state == REF_SETTLE && s.dly_cnt == '0 && conv_req |=> ref_out.ready)
        else $error("reference not ready after settle delay");

    a_no_settle_ungated: assert property ( // R12
        ce && s.ref_state == REF_IDLE && conv_req && !gated |=> ref_out.ready)
        else $error("settle delay applied without sleeping internal reference");

    a_always_on_ref: assert property ( // R13
        ce && s.ref_ctl[REF_SRC_POS] && !s.ref_ctl[REF_SLEEP_POS] |=> ref_out.power_on)
        else $error("internal reference off while set always on");

    a_external_ref_off: assert property ( // R14
        ce && !s.ref_ctl[REF_SRC_POS] |=> !ref_out.power_on)
        else $error("internal reference powered with external source");

    a_level_follows: assert property ( // R15
        ce && write_ref |=> ##1 !ce || ref_out.level_high == $past(word_in[REF_LVL_POS], 2))
        else $error("reference level does not follow its control bit");

endmodule : tsac_status_ref

// ===== testbench/tsac_host_model.sv
// Host side of the serial register port, mode 0, one data word per frame
module tsac_host_model
    import tsac_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      miso,
    input  wire logic      miso_oe,
    output tsac_spi_pins_t spi_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Half period well above the synchroniser lag of the device
    localparam int HALF = 10;

    initial spi_pins = PINS_IDLE;

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc

    // Fewer than 16 data bits ends the frame inside the word
    task automatic xfer(input logic [15:0] cmd, input logic [15:0] wdata, input int nbits,
                        output logic [15:0] rdata, output logic oe_ok);
        logic [31:0] sh;
        sh = {cmd, wdata};
        rdata = 16'h0000;
        oe_ok = 1'b1;
        @(negedge ref_clk);
        spi_pins.cs_n = 1'b0;
        for (int i = 0; i < 16 + nbits; i++)
        begin
            spi_pins.mosi = sh[31 - i];
            wait_cyc(HALF);
            if (i >= 16)
            begin
                rdata = {rdata[14:0], miso};
                oe_ok = oe_ok & miso_oe;
            end
            spi_pins.sclk = 1'b1;
            wait_cyc(HALF);
            spi_pins.sclk = 1'b0;
        end
        wait_cyc(HALF);
        spi_pins.cs_n = 1'b1;
        // Released data line must not keep its last level
        spi_pins.mosi = ~spi_pins.mosi;
        wait_cyc(8);
    endtask : xfer
endmodule : tsac_host_model

// ===== testbench/tb_touch_adc_status_and_reference_ctrl.sv
// Self-checking bench for the touch ADC status and reference control block
module tb_touch_adc_status_and_reference_ctrl
    import tsac_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int D500 = 20;
    localparam int D1000 = 40;
    localparam logic [4:0] REF_TBL [8] = '{5'h00, 5'h07, 5'h13, 5'h15, 5'h17, 5'h1b, 5'h1f,
                                          5'h02};

    logic           ref_clk;
    logic           srst;
    logic           ce;
    tsac_spi_pins_t spi_pins;
    logic           miso;
    logic           miso_oe;
    tsac_store_t    store;
    logic           set_done;
    logic           conv_req;
    tsac_ref_out_t  ref_out;
    int             error_cnt;
    int             checked;
    logic [15:0]    rd;
    logic           oe_ok;
    logic [15:0]    exp_stat;

    tsac_status_ref #(
        .DLY_500_CYC  (DLY_CNT_W'(D500)),
        .DLY_1000_CYC (DLY_CNT_W'(D1000))
    ) u_dut (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .spi_pins (spi_pins),
        .miso     (miso),
        .miso_oe  (miso_oe),
        .store    (store),
        .set_done (set_done),
        .conv_req (conv_req),
        .ref_out  (ref_out)
    );

    tsac_host_model u_host (
        .ref_clk  (ref_clk),
        .miso     (miso),
        .miso_oe  (miso_oe),
        .spi_pins (spi_pins)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_cnt(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t settle cycles %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : check_cnt

    function automatic logic [15:0] cmd_word(logic rd_n, logic [3:0] page, logic [5:0] addr);
        return {rd_n, page, addr, 5'h00};
    endfunction : cmd_word

    task automatic reg_read(input logic [3:0] page, input logic [5:0] addr);
        u_host.xfer(cmd_word(1'b1, page, addr), 16'h0000, 16, rd, oe_ok);
        check_word({15'h0000, oe_ok}, 16'h0001, "drive enable during read");
    endtask : reg_read

    task automatic reg_write(input logic [3:0] page, input logic [5:0] addr, input logic [15:0] d);
        u_host.xfer(cmd_word(1'b0, page, addr), d, 16, rd, oe_ok);
        check_word({15'h0000, oe_ok}, 16'h0000, "no drive during write");
    endtask : reg_write

    task automatic store_word(input logic [3:0] ch, input logic [15:0] d);
        @(negedge ref_clk);
        store = '{1'b1, ch, d};
        @(negedge ref_clk);
        store.valid = 1'b0;
    endtask : store_word

    task automatic ref_case(input logic [4:0] ctl);
        int   d;
        int   n;
        logic pwr;
        d = 0;
        n = 0;
        pwr = ctl[4] & ~ctl[1];
        if (ctl[4] && ctl[1])
        begin
            case (ctl[3:2])
                2'h1:    d = DLY_100_CYC;
                2'h2:    d = D500;
                2'h3:    d = D1000;
                default: d = 0;
            endcase
        end
        reg_write(PAGE_CONTROL, ADDR_REF_CTL, {11'h7ff, ctl});
        reg_read(PAGE_CONTROL, ADDR_REF_CTL);
        check_word(rd, {11'h000, ctl}, "ref ctl readback");
        check_word({12'h000, ref_out}, {12'h000, ctl[4], pwr, ctl[0], 1'b0}, "ref idle");
        conv_req = 1'b1;
        while (ref_out.ready !== 1'b1 && n < 2000)
        begin
            @(negedge ref_clk);
            n++;
            if (n == 1)
                check_word({15'h0000, ref_out.power_on}, {15'h0000, ctl[4]}, "ref power");
        end
        check_cnt(n, d + 1, d + 2);
        conv_req = 1'b0;
        @(negedge ref_clk);
        check_word({12'h000, ref_out}, {12'h000, ctl[4], pwr, ctl[0], 1'b0}, "ref release");
    endtask : ref_case

    task automatic report_and_stop();
        $display("Counts: errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Whole run is near 35k cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        store = '0;
        set_done = 1'b0;
        conv_req = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        check_word({12'h000, ref_out}, 16'h0000, "ref_out reset");
        reg_read(PAGE_CONTROL, ADDR_REF_CTL);
        check_word(rd, 16'h0002, "ref ctl reset");
        reg_write(PAGE_CONTROL, ADDR_STATUS, 16'hffff);
        reg_write(PAGE_CONTROL, ADDR_RESERVED, 16'h0000);
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, 16'h0000, "status reset");
        reg_read(PAGE_CONTROL, ADDR_RESERVED);
        check_word(rd, 16'hffff, "reserved word");
        reg_read(PAGE_CONTROL, 6'h3f);
        check_word(rd, 16'h0000, "unmapped read");
        for (int c = 0; c < CHAN_COUNT; c++)
            store_word(4'(c), 16'h1000 + 16'(c) * 16'h0111);
        @(negedge ref_clk);
        set_done = 1'b1;
        @(negedge ref_clk);
        set_done = 1'b0;
        exp_stat = 16'h0ff6;
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, exp_stat, "status all set");
        // Aborted result read must leave its flag alone
        u_host.xfer(cmd_word(1'b1, PAGE_RESULTS, 6'h00), 16'h0000, 8, rd, oe_ok);
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, exp_stat, "status after partial read");
        for (int c = 0; c < CHAN_COUNT; c++)
        begin
            reg_read(PAGE_RESULTS, 6'(c));
            check_word(rd, 16'h1000 + 16'(c) * 16'h0111, "result word");
            exp_stat[FLAG_POS[c]] = 1'b0;
            if (exp_stat[10:0] == 11'h000)
                exp_stat[11] = 1'b0;
            reg_read(PAGE_CONTROL, ADDR_STATUS);
            check_word(rd, exp_stat, "status after read");
        end
        store_word(4'h0, 16'habcd);
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, 16'h0400, "restored flag");
        reg_read(PAGE_RESULTS, 6'h00);
        check_word(rd, 16'habcd, "fresh result");
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, 16'h0000, "flag cleared again");
        // Store while frozen must leave flag and memory alone
        ce = 1'b0;
        store_word(4'h1, 16'h5555);
        ce = 1'b1;
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, 16'h0000, "store while frozen");
        reg_read(PAGE_RESULTS, 6'h01);
        check_word(rd, 16'h1111, "result kept while frozen");
        // Mid-run reset with a pending flag and a non-default reference setup
        reg_write(PAGE_CONTROL, ADDR_REF_CTL, 16'h001d);
        store_word(4'h2, 16'h0f0f);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        check_word({12'h000, ref_out}, 16'h0000, "ref_out mid-run reset");
        reg_read(PAGE_CONTROL, ADDR_REF_CTL);
        check_word(rd, 16'h0002, "ref ctl mid-run reset");
        reg_read(PAGE_CONTROL, ADDR_STATUS);
        check_word(rd, 16'h0000, "status mid-run reset");
        reg_read(PAGE_RESULTS, 6'h02);
        check_word(rd, 16'h0000, "result mid-run reset");
        foreach (REF_TBL[i])
            ref_case(REF_TBL[i]);
        report_and_stop();
    end
endmodule : tb_touch_adc_status_and_reference_ctrl
